//--- bench/bbp_ext_logic.sv
// bbp_ext_logic: external logic on the bit-bang pins
// assumes pull-ups on released pins, strobes from bbp_port
`timescale 1ns/100ps
module bbp_ext_logic (
  input  wire logic [7:0] dut_out,
  input  wire logic [7:0] dut_oe,
  input  wire logic [7:0] ext_oe,
  input  wire logic [7:0] ext_val,
  input  wire logic       wr_n,
  output logic      [7:0] pins,
  output logic      [7:0] last_byte
);
  always_comb
    for (int i = 0; i < 8; i++)
      pins[i] = dut_oe[i] ? dut_out[i] : (ext_oe[i] ? ext_val[i] : 1'b1);
  // latch the bus on the write strobe's rising edge
  always @(posedge wr_n) begin
    last_byte <= pins;
  end
endmodule

//--- bench/bbp_port_chk.sv
// bbp_port_chk: pin-side assertions for bbp_port
// assumes one clock mclk, synchronous active-low rst_n
`timescale 1ns/100ps
module bbp_port_chk (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [7:0] bus_out,
  input wire logic [7:0] bus_oe,
  input wire logic       bitbang_active,
  input wire logic       ctl_wr_n,
  input wire logic       ctl_rd_n,
  input wire logic       alt_wr_n,
  input wire logic       alt_rd_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_oe_when_off: assert property (!bitbang_active |-> bus_oe == 8'h00)
    else $error("pins driven while off");
  a_one_pair: assert property ((ctl_wr_n && ctl_rd_n) || (alt_wr_n && alt_rd_n))
    else $error("both strobe pairs active");
  a_ctl_wr_pulse: assert property ($fell(ctl_wr_n) |=> ctl_wr_n)
    else $error("ctl write pulse too long");
  a_alt_wr_pulse: assert property ($fell(alt_wr_n) |=> alt_wr_n)
    else $error("alt write pulse too long");
  a_strobe_active:
    assert property (($fell(ctl_wr_n) || $fell(alt_wr_n)) |-> bitbang_active)
    else $error("strobe while off");
  a_out_on_strobe:
    assert property ($changed(bus_out) |-> !(ctl_wr_n && ctl_rd_n && alt_wr_n && alt_rd_n))
    else $error("pins changed without strobe");
  a_ctl_order:
    assert property ($fell(ctl_rd_n) |=> !ctl_rd_n ##1 ($fell(ctl_wr_n) && !ctl_rd_n)
      ##1 ($rose(ctl_wr_n) && $rose(ctl_rd_n))) else $error("ctl access order");
  a_alt_order:
    assert property ($fell(alt_rd_n) |=> !alt_rd_n ##1 ($fell(alt_wr_n) && !alt_rd_n)
      ##1 ($rose(alt_wr_n) && $rose(alt_rd_n))) else $error("alt access order");
  c_sync_ctl: cover property ($fell(ctl_rd_n));
  c_sync_alt: cover property ($fell(alt_rd_n));
  c_async_alt: cover property ($fell(alt_wr_n) && alt_rd_n);
endmodule
bind bbp_port bbp_port_chk chk (.mclk(mclk), .rst_n(rst_n), .bus_out(bus_out),
  .bus_oe(bus_oe), .bitbang_active(bitbang_active), .ctl_wr_n(ctl_wr_n),
  .ctl_rd_n(ctl_rd_n), .alt_wr_n(alt_wr_n), .alt_rd_n(alt_rd_n));

//--- bench/test_bitbang_parallel_port.sv
// test_bitbang_parallel_port: self-checking bench for bbp_port
// assumes bbp_pkg, bbp_port, bbp_ext_logic and the checker bind
`timescale 1ns/100ps
module test_bitbang_parallel_port;
  import bbp_pkg::*;
  logic        mclk = 0;
  logic        rst_n = 0;
  logic        reg_wr = 0;
  logic        reg_rd = 0;
  logic [2:0]  reg_addr = 0;
  logic [15:0] reg_wdata = 0;
  logic [15:0] reg_rdata, rv;
  logic [7:0]  bus_in, bus_out, bus_oe, last_byte, d, ld;
  logic [7:0]  dir = 0;
  logic [7:0]  ev = 0;
  logic        bitbang_active, ctl_wr_n, ctl_rd_n, alt_wr_n, alt_rd_n;
  int          err_total = 0;
  int          checks_done = 0;
  int          seed = 32'h8de1;
  int          m, k, pm;
  int          q[$];
  bbp_port dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_in(bus_in),
    .bus_out(bus_out), .bus_oe(bus_oe), .bitbang_active(bitbang_active),
    .ctl_wr_n(ctl_wr_n), .ctl_rd_n(ctl_rd_n), .alt_wr_n(alt_wr_n), .alt_rd_n(alt_rd_n));
  bbp_ext_logic ext (.dut_out(bus_out), .dut_oe(bus_oe), .ext_oe(~dir), .ext_val(ev),
    .wr_n(ctl_wr_n & alt_wr_n), .pins(bus_in), .last_byte(last_byte));
  initial begin
    forever #10 mclk = ~mclk;
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #1000000;
    err_total++;
    finish_test();
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rreg(input logic [2:0] a, output logic [15:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // wait for the write strobe of one pair, then its release
  task automatic wait_wr(input bit alt);
    int n;
    for (n = 0; n < 400 && (alt ? alt_wr_n : ctl_wr_n) !== 1'b0; n++) begin
      @(posedge mclk);
      #1;
    end
    if (n == 400)
      chk(16'h0001, 16'h0000);
    @(posedge mclk);
    #1;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    wreg(BBP_REG_BAUD, 16'h000A);
    rreg(BBP_REG_BAUD, rv);
    chk(rv, 16'h0032);
    for (m = 0; m < 4; m++) begin
      dir = 8'($random(seed));
      ev  = 8'($random(seed));
      d = 8'($random(seed));
      wreg(BBP_REG_MAIN, 16'(m));
      wreg(BBP_REG_DIR, 16'(dir));
      wreg(BBP_REG_MODE, 16'(BBP_MODE_ASYNC));
      wreg(BBP_REG_DATA, 16'(d));
      wait_wr(m == 3);
      chk(16'(last_byte), 16'((d & dir) | (ev & ~dir)));
      chk(16'(bus_oe), 16'(dir));
      repeat (120) @(posedge mclk);
      #1;
      chk(16'(bus_out), 16'(d));
    end
    pm = (d & dir) | (ev & ~dir);
    for (m = 0; m < 4; m += 3) begin
      wreg(BBP_REG_MAIN, 16'(m));
      wreg(BBP_REG_MODE, 16'(BBP_MODE_SYNC));
      for (k = 0; k < 4; k++) begin
        ld = d;
        d = 8'($random(seed));
        wreg(BBP_REG_DATA, 16'(d));
        if (k > 0) begin
          repeat (120) @(posedge mclk);
          #1;
          chk(16'(bus_out), 16'(ld));
          rreg(BBP_REG_STATUS, rv);
          chk(rv, 16'h0003);
          rreg(BBP_REG_READBACK, rv);
          chk(rv, 16'(q.pop_front()));
        end
        q.push_back(pm);
        wait_wr(m == 3);
        pm = (d & dir) | (ev & ~dir);
      end
      rreg(BBP_REG_READBACK, rv);
      chk(rv, 16'(q.pop_front()));
    end
    wreg(BBP_REG_MODE, 16'(BBP_MODE_RESET));
    repeat (2) @(posedge mclk);
    #1;
    chk(16'(bus_oe), 16'h0000);
    chk(16'({bitbang_active, ctl_wr_n, ctl_rd_n, alt_wr_n, alt_rd_n}), 16'h000F);
    finish_test();
  end
endmodule

//--- hw/bbp_pkg.sv
// bbp_pkg: constants for the bit-bang parallel port
// assumes one 50 MHz clock, synchronous active-low reset
package bbp_pkg;
  localparam int          BBP_CLK_HZ        = 50000000;
  localparam int          BBP_BUS_W         = 8;
  // mode command values
  localparam logic [7:0]  BBP_MODE_RESET    = 8'h00;
  localparam logic [7:0]  BBP_MODE_ASYNC    = 8'h01;
  localparam logic [7:0]  BBP_MODE_SYNC     = 8'h04;
  // main channel modes
  localparam logic [1:0]  BBP_MAIN_FIFO     = 2'h0;
  localparam logic [1:0]  BBP_MAIN_CPUFIFO  = 2'h1;
  localparam logic [1:0]  BBP_MAIN_ISOSER   = 2'h2;
  localparam logic [1:0]  BBP_MAIN_UART     = 2'h3;
  // register indices
  localparam logic [2:0]  BBP_REG_MODE      = 3'h0;
  localparam logic [2:0]  BBP_REG_DIR       = 3'h1;
  localparam logic [2:0]  BBP_REG_DATA      = 3'h2;
  localparam logic [2:0]  BBP_REG_READBACK  = 3'h3;
  localparam logic [2:0]  BBP_REG_BAUD      = 3'h4;
  localparam logic [2:0]  BBP_REG_STATUS    = 3'h5;
  localparam logic [2:0]  BBP_REG_MAIN      = 3'h6;
  // reset values
  localparam logic [7:0]  BBP_DIR_RST       = 8'h00;
  localparam logic [15:0] BBP_BAUD_RST      = 16'h0063;
  // least baud divisor: keeps rate below 1 MBd at 50 MHz
  localparam int          BBP_MAX_BAUD      = 1000000;
  localparam logic [15:0] BBP_BAUD_MIN      = 16'((BBP_CLK_HZ + BBP_MAX_BAUD - 1) / BBP_MAX_BAUD);
  // status bit positions
  localparam int          BBP_ST_PEND       = 0;
  localparam int          BBP_ST_RBV        = 1;
  localparam int          BBP_ST_BUSY       = 2;
  localparam int          BBP_ST_OVR        = 3;
endpackage

//--- hw/bbp_port.sv
// bbp_port: one channel's bit-bang parallel port with strobe outputs
// assumes register port strobes synchronous to mclk, pin inputs synchronous
`timescale 1ns/100ps

module bbp_port #(
  parameter bit CHAN_B = 1'b0
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic [2:0]           reg_addr,
  input  wire logic [15:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [15:0]          reg_rdata,
  input  wire logic [bbp_pkg::BBP_BUS_W-1:0] bus_in,
  output logic      [bbp_pkg::BBP_BUS_W-1:0] bus_out,
  output logic      [bbp_pkg::BBP_BUS_W-1:0] bus_oe,
  output logic                      bitbang_active,
  output logic                      ctl_wr_n,
  output logic                      ctl_rd_n,
  output logic                      alt_wr_n,
  output logic                      alt_rd_n
);
  import bbp_pkg::*;

  if (BBP_BUS_W != 8) begin : g_bad_width
    $error("bus width must be 8");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_SAMPLE, ST_RD_HI, ST_RD_LO, ST_SETUP, ST_WR_LO, ST_WR_HI
  } bbp_state_t;

  typedef struct packed {
    logic [7:0]  mode;
    logic [1:0]  main;
    logic [7:0]  dir;
    logic [7:0]  pend_data;
    logic        pend;
    logic [7:0]  rb_data;
    logic        rb_valid;
    logic        ovr;
    logic [15:0] baud;
    logic [15:0] baud_cnt;
    bbp_state_t  st;
    logic [7:0]  out;
    logic [7:0]  oe;
    logic        act;
    logic        wr_n;
    logic        rd_n;
    logic        cwr_n;
    logic        crd_n;
    logic        awr_n;
    logic        ard_n;
    logic [15:0] rdata;
  } bbp_regs_t;

  bbp_regs_t s_reg;
  bbp_regs_t s_next;

  function automatic logic mode_on(input logic [7:0] m, input logic [1:0] mm);
    mode_on = (m == BBP_MODE_ASYNC || m == BBP_MODE_SYNC)
              && !(CHAN_B && mm == BBP_MAIN_ISOSER);
  endfunction

  logic tick;
  logic on;
  logic sync_m;

  always_comb begin
    s_next = s_reg;
    on     = mode_on(s_reg.mode, s_reg.main);
    sync_m = on && s_reg.mode == BBP_MODE_SYNC;
    tick   = (s_reg.baud_cnt == 16'h0000);
    // baud generator, one-cycle tick enable
    s_next.baud_cnt = tick ? s_reg.baud : s_reg.baud_cnt - 16'h0001;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        BBP_REG_MODE: begin
          s_next.mode = reg_wdata[7:0];
          s_next.st   = ST_IDLE;
          s_next.pend = 1'b0;
        end
        BBP_REG_DIR:  s_next.dir  = reg_wdata[7:0];
        BBP_REG_DATA: begin
          if (s_reg.pend) s_next.ovr = 1'b1;
          s_next.pend_data = reg_wdata[7:0];
          s_next.pend      = 1'b1;
        end
        BBP_REG_BAUD: s_next.baud = (reg_wdata < BBP_BAUD_MIN) ? BBP_BAUD_MIN : reg_wdata;
        BBP_REG_MAIN: s_next.main = reg_wdata[1:0];
        BBP_REG_STATUS: begin
          if (reg_wdata[BBP_ST_OVR]) s_next.ovr = 1'b0;
        end
        default: ;
      endcase
    end
    if (reg_rd && reg_addr == BBP_REG_READBACK) s_next.rb_valid = 1'b0;

    // byte engine
    case (s_reg.st)
      ST_IDLE: begin
        s_next.wr_n = 1'b1;
        s_next.rd_n = 1'b1;
        if (on && s_reg.pend && tick) begin
          if (!sync_m) begin
            s_next.out  = s_reg.pend_data;
            s_next.pend = 1'b0;
            s_next.wr_n = 1'b0;
            s_next.st   = ST_WR_HI;
          end else if (!s_reg.rb_valid) begin
            s_next.st   = ST_SAMPLE;
          end
        end
      end
      ST_SAMPLE: begin
        s_next.rb_data  = bus_in;
        s_next.rb_valid = 1'b1;
        s_next.st       = ST_RD_HI;
      end
      ST_RD_HI: begin
        s_next.rd_n = 1'b1;
        s_next.st   = ST_RD_LO;
      end
      ST_RD_LO: begin
        s_next.rd_n = 1'b0;
        s_next.out  = s_reg.pend_data;
        s_next.pend = 1'b0;
        s_next.st   = ST_SETUP;
      end
      ST_SETUP: s_next.st = ST_WR_LO;
      ST_WR_LO: begin
        s_next.wr_n = 1'b0;
        s_next.st   = ST_WR_HI;
      end
      ST_WR_HI: begin
        s_next.wr_n = 1'b1;
        s_next.rd_n = 1'b1;
        s_next.st   = ST_IDLE;
      end
      default: s_next.st = ST_IDLE;
    endcase
    // a data write in the same cycle as the update stays pending
    if (reg_wr && reg_addr == BBP_REG_DATA) s_next.pend = 1'b1;
    if (reg_wr && reg_addr == BBP_REG_MODE) s_next.pend = 1'b0;

    // pin drivers
    s_next.act = mode_on(s_next.mode, s_next.main);
    s_next.oe  = s_next.act ? s_next.dir : 8'h00;
    if (!s_next.act) begin
      s_next.wr_n = 1'b1;
      s_next.rd_n = 1'b1;
    end
    // strobe routing by main mode
    s_next.cwr_n = (s_next.main == BBP_MAIN_UART) ? 1'b1 : s_next.wr_n;
    s_next.crd_n = (s_next.main == BBP_MAIN_UART) ? 1'b1 : s_next.rd_n;
    s_next.awr_n = (s_next.main == BBP_MAIN_UART) ? s_next.wr_n : 1'b1;
    s_next.ard_n = (s_next.main == BBP_MAIN_UART) ? s_next.rd_n : 1'b1;

    // read data, one cycle later
    s_next.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        BBP_REG_MODE:     s_next.rdata = {8'h00, s_reg.mode};
        BBP_REG_DIR:      s_next.rdata = {8'h00, s_reg.dir};
        BBP_REG_DATA:     s_next.rdata = {8'h00, s_reg.out};
        BBP_REG_READBACK: s_next.rdata = {8'h00, s_reg.rb_data};
        BBP_REG_BAUD:     s_next.rdata = s_reg.baud;
        BBP_REG_STATUS:   s_next.rdata = {12'h000, s_reg.ovr, s_reg.st != ST_IDLE,
                                          s_reg.rb_valid, s_reg.pend};
        BBP_REG_MAIN:     s_next.rdata = {14'h0000, s_reg.main};
        default:          s_next.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_reg          <= '0;
      s_reg.dir      <= BBP_DIR_RST;
      s_reg.baud     <= BBP_BAUD_RST;
      s_reg.baud_cnt <= BBP_BAUD_RST;
      s_reg.st       <= ST_IDLE;
      s_reg.wr_n     <= 1'b1;
      s_reg.rd_n     <= 1'b1;
      s_reg.cwr_n    <= 1'b1;
      s_reg.crd_n    <= 1'b1;
      s_reg.awr_n    <= 1'b1;
      s_reg.ard_n    <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata      = s_reg.rdata;
  assign bus_out        = s_reg.out;
  assign bus_oe         = s_reg.oe;
  assign bitbang_active = s_reg.act;
  assign ctl_wr_n       = s_reg.cwr_n;
  assign ctl_rd_n       = s_reg.crd_n;
  assign alt_wr_n       = s_reg.awr_n;
  assign alt_rd_n       = s_reg.ard_n;

endmodule
